// File: logic/aprs_seq.sv
`timescale 1ns/1ps
`default_nettype none
module aprs_seq import aprs_pkg::*; #(
    parameter int CAL_CYCLES = APRS_CAL_CYCLES,
    parameter int LOAD_CYCLES = APRS_LOAD_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic reset_pin,
    input wire logic [1:0] reference_config_pin,
    input wire aprs_wr_type reg_wr,
    input wire logic [7:0] reg_rd_addr,
    output logic [7:0] reg_rd_data,
    output logic port_ready,
    output logic fuse_load,
    output logic cal_busy,
    output logic internal_ref
);
    localparam int CW = $clog2(CAL_CYCLES + 1);
    localparam logic [CW-1:0] CAL_LAST = CW'(CAL_CYCLES - 1);
    localparam logic [CW-1:0] LOAD_LAST = CW'(LOAD_CYCLES - 1);

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [2:0] pins_s;
    aprs_sync #(.WIDTH(3)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .async_in({reset_pin, reference_config_pin}),
        .sync_out(pins_s)
    );
    wire logic hw_reset_s = pins_s[2];
    wire logic [1:0] ref_s = pins_s[1:0];

    // ************************************************
    // Register decode
    // ************************************************
    // Self-clearing soft reset pulse, also a restart source
    logic soft_reset_q;
    // Soft reset is ignored while calibrating; host must wait anyway.
    // A second strobe during the pulse is dropped so the bit always clears.
    wire logic soft_wr = reg_wr.wr && port_ready && !soft_reset_q &&
        (reg_wr.addr == APRS_SOFT_RESET_ADDR);
    wire logic soft_hit = soft_wr && reg_wr.data[APRS_SOFT_RESET_BIT];
    wire logic seq_restart = hw_reset_s || soft_reset_q;

    // ************************************************
    // Sequencer state
    // ************************************************
    aprs_state_type state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic ref_int_q;

    // Next state: load fuses, then calibrate, then ready
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            APRS_ST_LOAD: begin
                if (cnt_q == LOAD_LAST) begin
                    state_d = APRS_ST_CAL;
                    cnt_d = '0;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            APRS_ST_CAL: begin
                if (cnt_q == CAL_LAST) begin
                    state_d = APRS_ST_READY;
                    cnt_d = '0;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            APRS_ST_READY: begin
                cnt_d = '0;
            end
            default: begin
                state_d = APRS_ST_LOAD;
                cnt_d = '0;
            end
        endcase
        // Reset held or soft pulse restarts at the fuse load
        if (seq_restart) begin
            state_d = APRS_ST_LOAD;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= APRS_ST_LOAD;
            cnt_q <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // Self-clearing soft reset bit, one cycle high
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            soft_reset_q <= 1'b0;
        end else if (clk_en) begin
            soft_reset_q <= soft_hit;
        end
    end

    // Reference mode latched when fuses load, so it stays stable later
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ref_int_q <= 1'b0;
        end else if (clk_en && state_q == APRS_ST_LOAD) begin
            ref_int_q <= (ref_s == APRS_REF_MID);
        end
    end

    // ************************************************
    // Outputs and readback
    // ************************************************
    // Status bits sit where the package places them; upper bits read zero
    wire logic [7:0] status_w;
    assign status_w[7:4] = 4'h0;
    assign status_w[APRS_STAT_REFINT_BIT] = ref_int_q;
    assign status_w[APRS_STAT_LOAD_BIT] = (state_q == APRS_ST_LOAD);
    assign status_w[APRS_STAT_CAL_BIT] = (state_q == APRS_ST_CAL);
    assign status_w[APRS_STAT_READY_BIT] = (state_q == APRS_ST_READY);
    // Readback select; unmapped addresses read zero
    wire logic sel_status = (reg_rd_addr == APRS_STATUS_ADDR);
    wire logic sel_soft = (reg_rd_addr == APRS_SOFT_RESET_ADDR);
    wire logic [7:0] rd_mux = sel_status ? status_w :
        sel_soft ? {7'h00, soft_reset_q} : 8'h00;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rd_data <= APRS_SOFT_RESET_RST;
            port_ready <= 1'b0;
            fuse_load <= 1'b1;
            cal_busy <= 1'b0;
            internal_ref <= 1'b0;
        end else if (clk_en) begin
            reg_rd_data <= rd_mux;
            port_ready <= (state_d == APRS_ST_READY);
            fuse_load <= (state_d == APRS_ST_LOAD);
            cal_busy <= (state_d == APRS_ST_CAL);
            internal_ref <= ref_int_q;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    soft_self_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && soft_reset_q ##1 clk_en |-> !soft_reset_q)
        else $error("soft reset bit did not clear");
    soft_restart_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && soft_reset_q |=> state_q == APRS_ST_LOAD)
        else $error("soft reset did not restart sequence");
    load_to_cal_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && !seq_restart && state_q == APRS_ST_LOAD && cnt_q == LOAD_LAST
        |=> state_q == APRS_ST_CAL)
        else $error("fuse load not followed by calibration");
    cal_done_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && !seq_restart && state_q == APRS_ST_CAL && cnt_q == CAL_LAST
        |=> state_q == APRS_ST_READY)
        else $error("calibration length wrong");
    ready_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(port_ready) |-> $past(state_q) == APRS_ST_CAL && $past(cnt_q) == CAL_LAST)
        else $error("port ready before calibration end");
    internal_ref_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && state_q == APRS_ST_LOAD && ref_s == APRS_REF_MID |=> ref_int_q)
        else $error("mid level did not select internal reference");

    // Restart and refusal
    restart_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && hw_reset_s |=> state_q == APRS_ST_LOAD && cnt_q == '0)
        else $error("reset pin did not hold the fuse load");
    soft_refused_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && reg_wr.wr && !port_ready |=> !soft_reset_q)
        else $error("soft reset taken before port ready");

    // Counter advance and reference hold
    cal_step_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && !seq_restart && state_q == APRS_ST_CAL && cnt_q != CAL_LAST
        |=> state_q == APRS_ST_CAL && cnt_q == $past(cnt_q) + 1'b1)
        else $error("calibration count skipped");
    ref_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && state_q != APRS_ST_LOAD |=> $stable(ref_int_q))
        else $error("reference mode changed outside fuse load");

    // ************************************************
    // Calibration length tally
    // ************************************************
    // Counted apart from the sequencer so a wrong end point is caught
    logic [CW-1:0] cal_seen_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cal_seen_q <= '0;
        end else if (clk_en) begin
            if (state_q == APRS_ST_CAL) begin
                cal_seen_q <= cal_seen_q + 1'b1;
            end else begin
                cal_seen_q <= '0;
            end
        end
    end
    cal_length_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(port_ready) |-> cal_seen_q == CW'(CAL_CYCLES))
        else $error("calibration did not last its full count");
endmodule : aprs_seq
`default_nettype wire

// File: logic/aprs_pkg.sv
package aprs_pkg;

    // ************************************************
    // Register map
    // ************************************************
    localparam logic [7:0] APRS_SOFT_RESET_ADDR = 8'h00; // soft_reset_control
    localparam int APRS_SOFT_RESET_BIT = 0;
    localparam logic [7:0] APRS_SOFT_RESET_RST = 8'h00;
    localparam logic [7:0] APRS_STATUS_ADDR = 8'h01; // Sequencer status, read only
    localparam int APRS_STAT_READY_BIT = 0;
    localparam int APRS_STAT_CAL_BIT = 1;
    localparam int APRS_STAT_LOAD_BIT = 2;
    localparam int APRS_STAT_REFINT_BIT = 3;

    // ************************************************
    // Timing
    // ************************************************
    localparam int APRS_CAL_CYCLES = 200000; // Sampling-clock cycles
    localparam int APRS_LOAD_CYCLES = 4; // Fuse load duration

    // Reference pin level codes from the front-end comparator
    localparam logic [1:0] APRS_REF_LOW = 2'b00;
    localparam logic [1:0] APRS_REF_MID = 2'b01; // Mid level, internal reference
    localparam logic [1:0] APRS_REF_HIGH = 2'b10;

    typedef enum logic [1:0] {
        APRS_ST_LOAD = 2'b00,
        APRS_ST_CAL = 2'b01,
        APRS_ST_READY = 2'b10
    } aprs_state_type;

    // Register write strobe with its data
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } aprs_wr_type;

endpackage : aprs_pkg

// File: logic/aprs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module aprs_sync import aprs_pkg::*; #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // ************************************************
    // Two-stage synchroniser per bit
    // ************************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // First stage feeds only the second stage
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    meta_q[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else if (clk_en) begin
                    meta_q[i] <= async_in[i];
                    sync_out[i] <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule : aprs_sync
`default_nettype wire

// File: test/aprs_host.sv
`timescale 1ns/1ps
`default_nettype none
module aprs_host import aprs_pkg::*; (
    input wire logic clock,
    output logic reset_pin,
    output logic [1:0] reference_config_pin,
    output aprs_wr_type reg_wr
);
    // ****************************
    // Host pin and port drivers
    // ****************************
    // Pin level fixed from the start, never floating
    initial begin
        reset_pin = 1'b0;
        reference_config_pin = APRS_REF_HIGH;
        reg_wr = '0;
    end
    // Level first, 13 cycles is over 100 ns, 125 cycles is 1 us
    task automatic hw_reset(input logic [1:0] code);
        @(negedge clock);
        reference_config_pin = code;
        repeat (13) @(negedge clock);
        reset_pin = 1'b1;
        repeat (125) @(negedge clock);
        reset_pin = 1'b0;
    endtask : hw_reset
    // One-cycle strobe; pin stays low meanwhile
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock);
        reg_wr = '{wr: 1'b1, addr: addr, data: data};
        @(negedge clock);
        reg_wr = '0;
    endtask : write_reg
endmodule : aprs_host
`default_nettype wire

// File: test/aprs_seq_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define APRS_CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
    err_total++; $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module aprs_seq_bench import aprs_pkg::*;;
    // Short calibration keeps the run brief
    localparam int CAL = 20;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic reset_pin;
    logic [1:0] reference_config_pin;
    aprs_wr_type reg_wr;
    logic [7:0] reg_rd_addr = 8'h00;
    logic [7:0] reg_rd_data;
    logic port_ready, fuse_load, cal_busy, internal_ref;
    int err_total = 0;
    int samples_checked = 0;
    int n;
    always #4 clock = ~clock;
    aprs_host aprs_host_inst (.clock(clock), .reset_pin(reset_pin),
        .reference_config_pin(reference_config_pin), .reg_wr(reg_wr));
    aprs_seq #(.CAL_CYCLES(CAL), .LOAD_CYCLES(4)) aprs_seq_inst (.clock(clock), .rst_n(rst_n),
        .clk_en(clk_en), .reset_pin(reset_pin), .reference_config_pin(reference_config_pin),
        .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
        .port_ready(port_ready), .fuse_load(fuse_load), .cal_busy(cal_busy),
        .internal_ref(internal_ref));
    // ****************************
    // Access tasks
    // ****************************
    task automatic read_chk(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge clock);
        reg_rd_addr = addr;
        @(posedge clock);
        #1;
        `APRS_CHECK(reg_rd_data, exp)
    endtask : read_chk
    // Bounded wait; counts calibration cycles on the way
    task automatic wait_ready();
        n = 0;
        repeat (CAL + 30) begin
            @(posedge clock);
            #1;
            if (cal_busy === 1'b1) n++;
            if (port_ready === 1'b1) break;
        end
        `APRS_CHECK(port_ready, 1'b1)
        `APRS_CHECK(n, CAL)
    endtask : wait_ready
    task automatic complete_run();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    // ****************************
    // Sequence
    // ****************************
    initial begin
        repeat (2) @(negedge clock);
        `APRS_CHECK({fuse_load, port_ready}, 2'b10)
        rst_n = 1'b1;
        aprs_host_inst.write_reg(APRS_SOFT_RESET_ADDR, 8'h01);
        `APRS_CHECK(port_ready, 1'b0)
        wait_ready();
        read_chk(APRS_STATUS_ADDR, 8'h01);
        // Wrong address or wrong bit must not restart
        aprs_host_inst.write_reg(APRS_STATUS_ADDR, 8'h01);
        aprs_host_inst.write_reg(APRS_SOFT_RESET_ADDR, 8'hfe);
        read_chk(APRS_SOFT_RESET_ADDR, APRS_SOFT_RESET_RST);
        `APRS_CHECK(port_ready, 1'b1)
        aprs_host_inst.write_reg(APRS_SOFT_RESET_ADDR, 8'h01);
        @(posedge clock);
        #1;
        `APRS_CHECK(reg_rd_data, 8'h01)
        @(posedge clock);
        #1;
        `APRS_CHECK({fuse_load, port_ready}, 2'b10)
        wait_ready();
        read_chk(APRS_SOFT_RESET_ADDR, APRS_SOFT_RESET_RST);
        aprs_host_inst.hw_reset(APRS_REF_MID);
        `APRS_CHECK({fuse_load, port_ready}, 2'b10)
        wait_ready();
        read_chk(APRS_STATUS_ADDR, 8'h09);
        `APRS_CHECK(internal_ref, 1'b1)
        aprs_host_inst.hw_reset(APRS_REF_LOW);
        wait_ready();
        `APRS_CHECK(internal_ref, 1'b0)
        // Frozen clock enable: a soft reset write must leave no trace
        @(negedge clock);
        clk_en = 1'b0;
        aprs_host_inst.write_reg(APRS_SOFT_RESET_ADDR, 8'h01);
        repeat (3) @(posedge clock);
        #1;
        `APRS_CHECK({fuse_load, cal_busy, port_ready}, 3'b001)
        @(negedge clock);
        clk_en = 1'b1;
        @(posedge clock);
        #1;
        `APRS_CHECK(port_ready, 1'b1)
        complete_run();
    end
    // Whole run is under 1000 cycles
    initial begin
        #20us;
        err_total++;
        complete_run();
    end
endmodule : aprs_seq_bench
`default_nettype wire
